// [sstd_top.sv]
// Split screen text display controller core
`timescale 1ns/10ps
// Notes on behaviour
// - Cursor hidden when first row exceeds last.
// - Underline solid 8-dot, broken 9-dot, graphics solid.
// - Index register then shared data port writes.
// - Glyph store host writable, 32 rows high.
// - Attribute bit 3 picks one of two fonts.
// - Eight fonts held, loadable while not shown.
// - Glyph row at code times 32 plus row.
// - Upper region from start, lower from zero.
// - Split match clears the address generator.
// - Next row start is 16-bit wrapping sum.
// - Split match forces pan zero until vsync.
// - Colour lookup 256 entries of 18 bits.
// - Mode bit 5 enables the pan override.
module sstd_top
(
   input  wire logic               REF_CLK_IN,
   input  wire logic               RESET_IN,
   input  wire logic               HOST_WR_IN,
   input  wire logic [2:0]         HOST_PORT_IN,
   input  wire logic [7:0]         HOST_WDATA_IN,
   output      logic [7:0]         HOST_RDATA_OUT,
   output      logic [1:0]         CLK_SEL_OUT,
   input  wire logic               GLYPH_WR_IN,
   input  wire logic [15:0]        GLYPH_ADDR_IN,
   input  wire logic [7:0]         GLYPH_DATA_IN,
   input  wire logic               LUT_WR_IN,
   input  wire logic [7:0]         LUT_WIDX_IN,
   input  wire sstd_pkg::sstd_rgb_s LUT_WDATA_IN,
   input  wire logic [7:0]         LUT_RIDX_IN,
   output      sstd_pkg::sstd_rgb_s LUT_RGB_OUT,
   input  wire logic               FRAME_START_IN,
   input  wire logic               LINE_START_IN,
   output      logic [15:0]        MEM_ADDR_OUT,
   input  wire logic               CELL_VALID_IN,
   output      logic               CELL_READY_OUT,
   input  wire logic [7:0]         CELL_CODE_IN,
   input  wire logic [7:0]         CELL_ATTR_IN,
   output      logic               OUT_VALID_OUT,
   input  wire logic               OUT_READY_IN,
   output      sstd_pkg::sstd_cell_s OUT_CELL_OUT,
   output      logic [3:0]         PAN_OUT
);

   // Line graphics code range test
   function automatic logic is_lg(input logic [7:0] code);
      is_lg = (code >= sstd_pkg::LG_FIRST) && (code <= sstd_pkg::LG_LAST);
   endfunction

   // Font number chosen by the map select and attribute bit
   function automatic logic [2:0] font_of(input logic [7:0] ms, input logic sel);
      font_of = sel ? {ms[5], ms[1:0]} : {ms[4], ms[3:2]};
   endfunction

   // ****************************************
   // Host register file
   // ****************************************
   logic [7:0] crt_reg [sstd_pkg::N_REGS];
   logic [7:0] atr_reg [sstd_pkg::N_REGS];
   logic [7:0] seq_reg [sstd_pkg::N_REGS];
   logic [7:0] crt_next [sstd_pkg::N_REGS];
   logic [7:0] atr_next [sstd_pkg::N_REGS];
   logic [7:0] seq_next [sstd_pkg::N_REGS];
   logic [4:0] crt_idx_reg, crt_idx_next;
   logic [4:0] atr_idx_reg, atr_idx_next;
   logic [4:0] seq_idx_reg, seq_idx_next;
   logic [7:0] misc_reg, misc_next;
   logic [7:0] rdata_next;

   // Index loads and shared data port writes
   always_comb
   begin
      crt_next     = crt_reg;
      atr_next     = atr_reg;
      seq_next     = seq_reg;
      crt_idx_next = crt_idx_reg;
      atr_idx_next = atr_idx_reg;
      seq_idx_next = seq_idx_reg;
      misc_next    = misc_reg;
      if (HOST_WR_IN)
      begin
         case (HOST_PORT_IN)
            sstd_pkg::P_CRT_IDX: crt_idx_next = HOST_WDATA_IN[4:0];
            sstd_pkg::P_CRT_DAT: crt_next[crt_idx_reg] = HOST_WDATA_IN;
            sstd_pkg::P_ATR_IDX: atr_idx_next = HOST_WDATA_IN[4:0];
            sstd_pkg::P_ATR_DAT: atr_next[atr_idx_reg] = HOST_WDATA_IN;
            sstd_pkg::P_SEQ_IDX: seq_idx_next = HOST_WDATA_IN[4:0];
            sstd_pkg::P_SEQ_DAT: seq_next[seq_idx_reg] = HOST_WDATA_IN;
            sstd_pkg::P_MISC:    misc_next = HOST_WDATA_IN;
            default:             misc_next = misc_reg;
         endcase
      end
   end

   // Read back of the selected register
   always_comb
   begin
      case (HOST_PORT_IN)
         sstd_pkg::P_CRT_IDX: rdata_next = {3'h0, crt_idx_reg};
         sstd_pkg::P_CRT_DAT: rdata_next = crt_reg[crt_idx_reg];
         sstd_pkg::P_ATR_IDX: rdata_next = {3'h0, atr_idx_reg};
         sstd_pkg::P_ATR_DAT: rdata_next = atr_reg[atr_idx_reg];
         sstd_pkg::P_SEQ_IDX: rdata_next = {3'h0, seq_idx_reg};
         sstd_pkg::P_SEQ_DAT: rdata_next = seq_reg[seq_idx_reg];
         sstd_pkg::P_MISC:    rdata_next = misc_reg;
         default:             rdata_next = sstd_pkg::REG_RST;
      endcase
   end

   // Register file flops
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         for (int i = 0; i < sstd_pkg::N_REGS; i++)
         begin
            crt_reg[i] <= sstd_pkg::REG_RST;
            atr_reg[i] <= sstd_pkg::REG_RST;
            seq_reg[i] <= sstd_pkg::REG_RST;
         end
         crt_idx_reg    <= 5'h00;
         atr_idx_reg    <= 5'h00;
         seq_idx_reg    <= 5'h00;
         misc_reg       <= sstd_pkg::REG_RST;
         HOST_RDATA_OUT <= sstd_pkg::REG_RST;
      end
      else
      begin
         crt_reg        <= crt_next;
         atr_reg        <= atr_next;
         seq_reg        <= seq_next;
         crt_idx_reg    <= crt_idx_next;
         atr_idx_reg    <= atr_idx_next;
         seq_idx_reg    <= seq_idx_next;
         misc_reg       <= misc_next;
         HOST_RDATA_OUT <= rdata_next;
      end
   end

   assign CLK_SEL_OUT = misc_reg[3:2];

   // ****************************************
   // Glyph store and colour lookup
   // ****************************************
   logic [7:0]          glyph_mem [sstd_pkg::GLYPH_SIZE];
   sstd_pkg::sstd_rgb_s lut_mem [sstd_pkg::LUT_SIZE];

   // Host loads of fonts and colours
   always_ff @(posedge REF_CLK_IN)
   begin
      if (GLYPH_WR_IN)
         glyph_mem[GLYPH_ADDR_IN] <= GLYPH_DATA_IN;
      if (LUT_WR_IN)
         lut_mem[LUT_WIDX_IN] <= LUT_WDATA_IN;
   end

   // Registered colour output
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
         LUT_RGB_OUT <= '0;
      else
         LUT_RGB_OUT <= lut_mem[LUT_RIDX_IN];
   end

   // ****************************************
   // Line and address generation
   // ****************************************
   logic [7:0]  scan_reg, scan_next;
   logic [4:0]  row_reg, row_next;
   logic [15:0] lstart_reg, lstart_next;
   logic [15:0] addr_reg, addr_next;
   logic        split_reg, split_next;
   logic [15:0] start_addr, offset, row_sum;
   logic        match, take, in_rdy;

   assign start_addr = {crt_reg[sstd_pkg::C_START_HI], crt_reg[sstd_pkg::C_START_LO]};
   assign offset     = {8'h00, crt_reg[sstd_pkg::C_OFFSET]};
   assign row_sum    = 16'(lstart_reg + offset);
   assign match      = scan_reg == crt_reg[sstd_pkg::C_SPLIT];

   // Frame, line and cell address stepping
   always_comb
   begin
      scan_next   = scan_reg;
      row_next    = row_reg;
      lstart_next = lstart_reg;
      addr_next   = addr_reg;
      split_next  = split_reg;
      if (FRAME_START_IN)
      begin
         scan_next   = 8'h00;
         row_next    = 5'h00;
         lstart_next = start_addr;
         addr_next   = start_addr;
         split_next  = 1'b0;
      end
      else if (LINE_START_IN)
      begin
         scan_next = 8'(scan_reg + 8'h01);
         if (match)
         begin
            row_next    = 5'h00;
            lstart_next = sstd_pkg::ADDR_RST;
            addr_next   = sstd_pkg::ADDR_RST;
            split_next  = 1'b1;
         end
         else if (row_reg == crt_reg[sstd_pkg::C_MAX_ROW][4:0])
         begin
            row_next    = 5'h00;
            lstart_next = row_sum;
            addr_next   = row_sum;
         end
         else
         begin
            row_next  = 5'(row_reg + 5'h01);
            addr_next = lstart_reg;
         end
      end
      else if (take)
         addr_next = 16'(addr_reg + 16'h0001);
   end

   // Line state flops
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         scan_reg   <= 8'h00;
         row_reg    <= 5'h00;
         lstart_reg <= sstd_pkg::ADDR_RST;
         addr_reg   <= sstd_pkg::ADDR_RST;
         split_reg  <= 1'b0;
      end
      else
      begin
         scan_reg   <= scan_next;
         row_reg    <= row_next;
         lstart_reg <= lstart_next;
         addr_reg   <= addr_next;
         split_reg  <= split_next;
      end
   end

   assign MEM_ADDR_OUT = addr_reg;
   assign PAN_OUT = (split_reg && atr_reg[sstd_pkg::A_MODE][sstd_pkg::B_PAN_COMPAT])
                    ? 4'h0 : atr_reg[sstd_pkg::A_PAN][3:0];

   // ****************************************
   // Cell rendering stage
   // ****************************************
   logic [4:0]  cur_top, cur_bot, ul_row;
   logic [2:0]  font;
   logic [15:0] gaddr;
   logic [7:0]  gbyte;
   logic        nine, lg_on, ul_hit, cur_hit;
   logic [8:0]  dots;
   logic        st_v_reg, st_v_next, push;
   sstd_pkg::sstd_cell_s st_reg, st_next;

   assign cur_top = crt_reg[sstd_pkg::C_CUR_TOP][4:0];
   assign cur_bot = crt_reg[sstd_pkg::C_CUR_BOT][4:0];
   assign ul_row  = crt_reg[sstd_pkg::C_UL_ROW][4:0];
   assign font    = font_of(seq_reg[sstd_pkg::S_MAPSEL],
                            CELL_ATTR_IN[sstd_pkg::B_FONT_SEL]);
   assign gaddr   = {font, CELL_CODE_IN, row_reg};
   assign gbyte   = glyph_mem[gaddr];
   assign nine    = !seq_reg[sstd_pkg::S_CLKMODE][sstd_pkg::B_DOT8];
   assign lg_on   = atr_reg[sstd_pkg::A_MODE][sstd_pkg::B_LINE_GFX] && is_lg(CELL_CODE_IN);
   assign ul_hit  = (CELL_ATTR_IN[2:0] == 3'h1) && (row_reg == ul_row);
   assign cur_hit = !crt_reg[sstd_pkg::C_CUR_TOP][sstd_pkg::B_CUR_OFF]
                    && (cur_top <= cur_bot)
                    && (row_reg >= cur_top) && (row_reg <= cur_bot)
                    && (addr_reg == {crt_reg[sstd_pkg::C_CLOC_HI],
                                     crt_reg[sstd_pkg::C_CLOC_LO]});

   // Dot pattern with ninth dot and underline
   always_comb
   begin
      if (ul_hit)
         dots = {8'hff, nine && lg_on};
      else
         dots = {gbyte, nine && lg_on && gbyte[0]};
   end

   assign take   = CELL_VALID_IN && CELL_READY_OUT;
   assign in_rdy = !st_v_reg || push;
   assign CELL_READY_OUT = in_rdy && !LINE_START_IN && !FRAME_START_IN;

   // Stage capture, held while the buffer is full
   always_comb
   begin
      st_next   = st_reg;
      st_v_next = st_v_reg && !push;
      if (take)
      begin
         st_next   = '{dots: dots, cursor: cur_hit, attr: CELL_ATTR_IN, pan: PAN_OUT};
         st_v_next = 1'b1;
      end
   end

   // Stage flops
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         st_reg   <= '0;
         st_v_reg <= 1'b0;
      end
      else
      begin
         st_reg   <= st_next;
         st_v_reg <= st_v_next;
      end
   end

   // ****************************************
   // Two entry output buffer
   // ****************************************
   sstd_pkg::sstd_cell_s buf_reg [2];
   sstd_pkg::sstd_cell_s buf_next [2];
   logic [1:0] cnt_reg, cnt_next;
   logic       wp_reg, wp_next, rp_reg, rp_next, pop;

   assign push = st_v_reg && (cnt_reg != sstd_pkg::CNT_FULL);
   assign pop  = OUT_READY_IN && (cnt_reg != 2'h0);
   assign OUT_VALID_OUT = cnt_reg != 2'h0;
   assign OUT_CELL_OUT  = buf_reg[rp_reg];

   // Buffer pointers and count
   always_comb
   begin
      buf_next = buf_reg;
      wp_next  = wp_reg ^ push;
      rp_next  = rp_reg ^ pop;
      cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
      if (push)
         buf_next[wp_reg] = st_reg;
   end

   // Buffer flops
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
         cnt_reg    <= 2'h0;
         wp_reg     <= 1'b0;
         rp_reg     <= 1'b0;
      end
      else
      begin
         buf_reg <= buf_next;
         cnt_reg <= cnt_next;
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);

   AST_CURSOR_OFF: assert property (take && cur_top > cur_bot |=> !st_reg.cursor)
      else $error("cursor shown with first row above last");
   AST_UL_NINE: assert property (take && ul_hit && nine && !lg_on
      |=> st_reg.dots == 9'h1fe)
      else $error("nine dot underline not broken");
   AST_UL_LG: assert property (take && ul_hit && nine && lg_on
      |=> st_reg.dots == 9'h1ff)
      else $error("line graphics underline not solid");
   AST_IDX_WR: assert property (HOST_WR_IN && HOST_PORT_IN == sstd_pkg::P_CRT_DAT
      |=> crt_reg[$past(crt_idx_reg)] == $past(HOST_WDATA_IN))
      else $error("indexed write lost");
   AST_GLYPH_WR: assert property (GLYPH_WR_IN
      |=> glyph_mem[$past(GLYPH_ADDR_IN)] == $past(GLYPH_DATA_IN))
      else $error("glyph write lost");
   AST_FONT: assert property (take && CELL_ATTR_IN[3]
      |-> gaddr[15:13] == {seq_reg[3][5], seq_reg[3][1:0]})
      else $error("wrong font chosen");
   AST_ROW_OFS: assert property (take
      |-> gaddr[12:0] == 13'(CELL_CODE_IN * 32 + row_reg))
      else $error("glyph row offset wrong");
   AST_SPLIT: assert property (LINE_START_IN && !FRAME_START_IN && match
      |=> addr_reg == 16'h0000 && lstart_reg == 16'h0000 && split_reg)
      else $error("split did not clear address");
   AST_FRAME: assert property (FRAME_START_IN
      |=> addr_reg == $past(start_addr) && !split_reg)
      else $error("upper region not at start address");
   AST_ROW_SUM: assert property (LINE_START_IN && !FRAME_START_IN && !match
      && row_reg == crt_reg[9][4:0]
      |=> lstart_reg == 16'($past(lstart_reg) + $past(offset)))
      else $error("row start sum wrong");
   AST_PAN_ZERO: assert property (split_reg && atr_reg[16][5] |-> PAN_OUT == 4'h0)
      else $error("pan not forced to zero");
   AST_PAN_KEEP: assert property (!atr_reg[16][5] |-> PAN_OUT == atr_reg[19][3:0])
      else $error("pan changed without compat");

   COV_SPLIT: cover property (LINE_START_IN && match ##1 split_reg);
   COV_FULL:  cover property (cnt_reg == 2'h2 && !OUT_READY_IN);
   COV_CUR:   cover property (take && cur_hit);
   COV_FONT2: cover property (take && font != font_of(seq_reg[3], 1'b0));
endmodule

// [sstd_pkg.sv]
// Package of constants and types for the split screen text display
package sstd_pkg;
   // Host port selects
   localparam logic [2:0] P_CRT_IDX  = 3'h0;
   localparam logic [2:0] P_CRT_DAT  = 3'h1;
   localparam logic [2:0] P_ATR_IDX  = 3'h2;
   localparam logic [2:0] P_ATR_DAT  = 3'h3;
   localparam logic [2:0] P_SEQ_IDX  = 3'h4;
   localparam logic [2:0] P_SEQ_DAT  = 3'h5;
   localparam logic [2:0] P_MISC     = 3'h6;
   // Display controller indices
   localparam logic [4:0] C_MAX_ROW  = 5'h09;
   localparam logic [4:0] C_CUR_TOP  = 5'h0a;
   localparam logic [4:0] C_CUR_BOT  = 5'h0b;
   localparam logic [4:0] C_START_HI = 5'h0c;
   localparam logic [4:0] C_START_LO = 5'h0d;
   localparam logic [4:0] C_CLOC_HI  = 5'h0e;
   localparam logic [4:0] C_CLOC_LO  = 5'h0f;
   localparam logic [4:0] C_OFFSET   = 5'h13;
   localparam logic [4:0] C_UL_ROW   = 5'h14;
   localparam logic [4:0] C_SPLIT    = 5'h19;
   // Attribute and sequencer indices
   localparam logic [4:0] A_MODE     = 5'h10;
   localparam logic [4:0] A_PAN      = 5'h13;
   localparam logic [4:0] S_CLKMODE  = 5'h01;
   localparam logic [4:0] S_MAPSEL   = 5'h03;
   // Field positions
   localparam int B_PAN_COMPAT = 5;
   localparam int B_LINE_GFX   = 2;
   localparam int B_CUR_OFF    = 5;
   localparam int B_DOT8       = 0;
   localparam int B_FONT_SEL   = 3;
   // Line graphics code range
   localparam logic [7:0] LG_FIRST   = 8'hc0;
   localparam logic [7:0] LG_LAST    = 8'hdf;
   // Sizes and reset values
   localparam int N_REGS     = 32;
   localparam int GLYPH_SIZE = 65536;
   localparam int LUT_SIZE   = 256;
   localparam logic [7:0]  REG_RST  = 8'h00;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [1:0]  CNT_FULL = 2'h2;
   // Colour entry, six bits per primary
   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } sstd_rgb_s;
   // One rendered cell row
   typedef struct packed {
      logic [8:0] dots;
      logic       cursor;
      logic [7:0] attr;
      logic [3:0] pan;
   } sstd_cell_s;
endpackage

// [sstd_sink.sv]
// Downstream display model that takes rendered cells with random stalls
`timescale 1ns/10ps
module sstd_sink
(
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic stall_in,
   output      logic ready_out
);
   integer seed = 80;

   // Ready moves off the sampling edge, held low while stalled
   always @(negedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         ready_out <= 1'b0;
      else if (stall_in)
         ready_out <= 1'b0;
      else
         ready_out <= ($random(seed) & 32'h0000_0003) != 32'h0000_0000;
   end
endmodule

// [sstd_top_tb.sv]
// Self-checking testbench for the split screen text display core
`timescale 1ns/10ps
module sstd_top_tb;
   logic clk = 1'b0, rst = 1'b1, host_wr = 1'b0, glyph_wr = 1'b0, lut_wr = 1'b0;
   logic frame_start = 1'b0, line_start = 1'b0, cell_valid = 1'b0, stall = 1'b1;
   logic [2:0] host_port = 3'h0;
   logic [7:0] host_wdata = 8'h00, cell_code = 8'h00, cell_attr = 8'h00;
   logic [7:0] lut_widx = 8'h00, lut_ridx = 8'h00, glyph_data = 8'h00, host_rdata;
   logic [15:0] glyph_addr = 16'h0000, mem_addr, next_addr;
   sstd_pkg::sstd_rgb_s lut_wdata = '0, lut_rgb;
   sstd_pkg::sstd_cell_s out_cell;
   logic [1:0] clk_sel;
   logic [3:0] pan;
   logic cell_ready, out_valid, out_ready, dot8;
   logic [7:0] map_sel = 8'h27, cur_loc, gl [0:7][0:255];
   logic [7:0] codes [0:3] = '{8'hc0, 8'hdf, 8'h41, 8'hbf};
   logic [4:0] cur_top, cur_bot;
   logic [3:0] pan_exp;
   logic [21:0] q_exp[$], q_msk[$], m_exp, m_msk;
   integer seed = 80, err_count = 0, compares = 0;

   // Clock and instances
   always #5 clk = ~clk;
   sstd_top u_sstd_top (.REF_CLK_IN(clk), .RESET_IN(rst), .HOST_WR_IN(host_wr),
      .HOST_PORT_IN(host_port), .HOST_WDATA_IN(host_wdata), .HOST_RDATA_OUT(host_rdata),
      .CLK_SEL_OUT(clk_sel), .GLYPH_WR_IN(glyph_wr), .GLYPH_ADDR_IN(glyph_addr),
      .GLYPH_DATA_IN(glyph_data), .LUT_WR_IN(lut_wr), .LUT_WIDX_IN(lut_widx),
      .LUT_WDATA_IN(lut_wdata), .LUT_RIDX_IN(lut_ridx), .LUT_RGB_OUT(lut_rgb),
      .FRAME_START_IN(frame_start), .LINE_START_IN(line_start), .MEM_ADDR_OUT(mem_addr),
      .CELL_VALID_IN(cell_valid), .CELL_READY_OUT(cell_ready), .CELL_CODE_IN(cell_code),
      .CELL_ATTR_IN(cell_attr), .OUT_VALID_OUT(out_valid), .OUT_READY_IN(out_ready),
      .OUT_CELL_OUT(out_cell), .PAN_OUT(pan));
   sstd_sink u_sstd_sink (.clk_in(clk), .reset_in(rst), .stall_in(stall),
      .ready_out(out_ready));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic fail_out;
      err_count = err_count + 1;
      tally_and_finish;
   endtask

   // Host write, strobe left high for back to back use
   task automatic wr(input logic [2:0] p, input logic [7:0] d);
      host_port = p;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk);
   endtask

   // Index then shared data port
   task automatic reg_wr(input logic [2:0] p, input logic [4:0] idx, input logic [7:0] d);
      wr(p, {3'h0, idx});
      wr(p + 3'h1, d);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask

   // Expected cell at row zero below the split
   function automatic logic [21:0] exp_cell(input logic [7:0] code, input logic [7:0] attr,
                                            input logic [15:0] addr);
      logic [2:0] font;
      logic [7:0] g;
      logic lg;
      logic [8:0] dots;
      logic cur;
      font = attr[3] ? {map_sel[5], map_sel[1:0]} : {map_sel[4], map_sel[3:2]};
      g = gl[font][code];
      lg = code >= sstd_pkg::LG_FIRST && code <= sstd_pkg::LG_LAST;
      dots = (attr[2:0] == 3'h1) ? ((!dot8 && lg) ? 9'h1ff : 9'h1fe) : {g, lg & g[0]};
      cur = cur_top <= cur_bot && cur_top == 5'h00 && addr[7:0] == cur_loc;
      return {dots, cur, attr, pan_exp};
   endfunction

   // Frame then five lines, split after scan line four
   task automatic walk_frame(input logic compat);
      logic [15:0] ls;
      logic [4:0] row;
      reg_wr(sstd_pkg::P_ATR_IDX, sstd_pkg::A_MODE, {2'h0, compat, 5'h04});
      host_wr = 1'b0;
      pulse(frame_start);
      ls = 16'hfff8;
      row = 5'h00;
      check(24'(mem_addr), 24'(ls));
      check(24'(pan), 24'h00_0005);
      for (int k = 0; k < 5; k++)
      begin
         pulse(line_start);
         if (row == 5'h01)
            ls = ls + 16'h0010;
         row = (row == 5'h01) ? 5'h00 : row + 5'h01;
         check(24'(mem_addr), (k == 4) ? 24'h00_0000 : 24'(ls));
      end
      check(24'(pan), compat ? 24'h00_0000 : 24'h00_0005);
   endtask

   // Stream cells with an early sink stall, then drain
   task automatic batch(input int n);
      int wait_n;
      int refused;
      stall <= 1'b1;
      refused = 0;
      for (int i = 0; i < n; i++)
      begin
         cell_valid = 1'b1;
         cell_code = codes[$random(seed) & 3];
         cell_attr = 8'($random(seed));
         if (i % 3 == 0)
            cell_attr[2:0] = 3'h1;
         wait_n = 0;
         #1;
         while (cell_ready !== 1'b1 && wait_n < 50)
         begin
            refused++;
            wait_n++;
            if (wait_n == 8)
               stall = 1'b0;
            @(negedge clk);
            #1;
         end
         if (wait_n == 50)
            fail_out;
         check(24'(mem_addr), 24'(next_addr));
         q_exp.push_back(exp_cell(cell_code, cell_attr, next_addr));
         q_msk.push_back(dot8 ? 22'h3f_dfff : 22'h3f_ffff);
         next_addr++;
         @(negedge clk);
      end
      cell_valid = 1'b0;
      check(24'(refused > 0), 24'h00_0001);
      wait_n = 0;
      while ((q_exp.size() != 0 || out_valid !== 1'b0) && wait_n < 200)
      begin
         wait_n++;
         @(negedge clk);
      end
      if (wait_n == 200)
         fail_out;
   endtask

   // ****************************************
   // Output monitor against the note queue
   // ****************************************
   always @(posedge clk)
   begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (q_exp.size() == 0)
            check(24'h00_0001, 24'h00_0000);
         else
         begin
            m_msk = q_msk.pop_front();
            m_exp = q_exp.pop_front();
            check(24'(out_cell & m_msk), 24'(m_exp & m_msk));
         end
      end
   end

   // Main sequence
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      reg_wr(sstd_pkg::P_SEQ_IDX, 5'h00, 8'h01);
      reg_wr(sstd_pkg::P_SEQ_IDX, sstd_pkg::S_CLKMODE, 8'h00);
      wr(sstd_pkg::P_MISC, 8'h0c);
      reg_wr(sstd_pkg::P_SEQ_IDX, 5'h00, 8'h03);
      reg_wr(sstd_pkg::P_SEQ_IDX, sstd_pkg::S_MAPSEL, map_sel);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_MAX_ROW, 8'h01);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_OFFSET, 8'h10);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_UL_ROW, 8'h00);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CUR_TOP, 8'h00);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CUR_BOT, 8'h05);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CLOC_LO, 8'h03);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_START_HI, 8'hff);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_START_LO, 8'hf7);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_SPLIT, 8'h04);
      host_wr = 1'b0;
      @(negedge clk);
      check(24'(host_rdata), 24'h00_0004);
      check(24'(clk_sel), 24'h00_0003);
      host_port = sstd_pkg::P_CRT_IDX;
      @(negedge clk);
      check(24'(host_rdata), 24'h00_0019);
      host_port = 3'h7;
      @(negedge clk);
      check(24'(host_rdata), 24'h00_0000);
      // Panning step inside the four bit register field
      reg_wr(sstd_pkg::P_ATR_IDX, sstd_pkg::A_PAN, 8'h07);
      host_wr = 1'b0;
      check(24'(pan), 24'h00_0007);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_START_LO, 8'hf8);
      reg_wr(sstd_pkg::P_ATR_IDX, sstd_pkg::A_PAN, 8'h00);
      host_wr = 1'b0;
      check(24'(pan), 24'h00_0000);
      reg_wr(sstd_pkg::P_ATR_IDX, sstd_pkg::A_PAN, 8'h05);
      host_wr = 1'b0;
      // Colour lookup write then read back
      for (int i = 0; i < 2; i++)
      begin
         lut_wr = 1'b1;
         lut_widx = i[0] ? 8'hff : 8'h00;
         lut_wdata = 18'($random(seed));
         @(negedge clk);
         lut_wr = 1'b0;
         lut_ridx = lut_widx;
         @(negedge clk);
         check(24'(lut_rgb), 24'(lut_wdata));
      end
      // Rows 0 and 31 of four codes in all eight fonts
      for (int f = 0; f < 8; f++)
         for (int k = 0; k < 4; k++)
            for (int r = 0; r < 32; r += 31)
            begin
               glyph_wr = 1'b1;
               glyph_addr = {f[2:0], codes[k], r[4:0]};
               glyph_data = 8'($random(seed));
               if (r == 0)
                  gl[f][codes[k]] = glyph_data;
               @(negedge clk);
            end
      glyph_wr = 1'b0;
      walk_frame(1'b0);
      walk_frame(1'b1);
      {cur_top, cur_bot, cur_loc, dot8} = {5'h00, 5'h05, 8'h03, 1'b0};
      {pan_exp, next_addr} = {4'h0, 16'h0000};
      batch(12);
      reg_wr(sstd_pkg::P_SEQ_IDX, 5'h00, 8'h01);
      reg_wr(sstd_pkg::P_SEQ_IDX, sstd_pkg::S_CLKMODE, 8'h01);
      reg_wr(sstd_pkg::P_SEQ_IDX, 5'h00, 8'h03);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CUR_TOP, 8'h01);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CUR_BOT, 8'h00);
      reg_wr(sstd_pkg::P_CRT_IDX, sstd_pkg::C_CLOC_LO, 8'h0d);
      host_wr = 1'b0;
      {cur_top, cur_bot, cur_loc, dot8} = {5'h01, 5'h00, 8'h0d, 1'b1};
      batch(12);
      pulse(frame_start);
      check(24'(pan), 24'h00_0005);
      tally_and_finish;
   end
endmodule
